/* hdl/dsebc_ctrl.sv */
// Sector ECC buffer controller: serial link engine, three sector buffers, Avalon-MM registers
//
// How it works
// RULE1: raw read stores check bytes as data
// RULE2: raw write sends supplied check bytes unchanged
// RULE3: raw commands bypass check generation and checking
// RULE4: altered record on normal read flags error
// RULE5: diagnostic mode never asserts write gate
// RULE6: diagnostic feeds write data through checker
// RULE7: one buffer plus interleave three allowed
// RULE8: two buffers rely on faster host unload
// RULE9: three buffers rotate fill, correct, drain
// RULE10: correction waits for data and syndrome
// RULE11: buffer reaches host only after correction
// RULE12: orientation lost when no buffer free
// RULE13: drive sends erasure pointers on read data
// RULE14: pointers aligned with the marked byte
// RULE15: pointers replace data and check bytes only
// RULE16: other fields sent as normal read
// RULE17: drive picks bad-byte criteria
// RULE18: erasure reread places pointers in buffer
// RULE19: thresholds raise sector and medium retire flags
// RULE20: sector address derived from orientation count
// RULE21: syndrome and error flag given per sector
`timescale 1ns/1ps
`default_nettype none
`include "dsebc_regs.svh"
module dsebc_ctrl
  import dsebc_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic rd_clk_i,
  input wire logic rd_data_i,
  output dsebc_link_s link_o
);
  logic ack;
  logic req;
  logic wr_acc;
  logic rd_acc;
  logic [5:0] wa;
  dsebc_op_e op;
  logic [1:0] nbm1;
  logic [7:0] sec_thr;
  logic [7:0] med_thr;
  logic [7:0] marg;
  logic [15:0] sect;
  logic rsec;
  logic rmed;
  logic olost;
  logic [2:0] clk_s;
  logic [1:0] dat_s;
  logic edge_p;
  dsebc_st_e st;
  logic [2:0] bitc;
  logic [7:0] bcnt;
  logic [7:0] sh;
  logic [7:0] rbyte;
  logic [7:0] src;
  logic [7:0] hptr;
  logic [7:0] dptr;
  logic [1:0] fill_ix;
  logic [1:0] corr_ix;
  logic [1:0] drain_ix;
  logic [7:0] mem [0:2][0:135];
  dsebc_bst_e bst [0:2];
  logic [63:0] syn [0:2];
  logic [2:0] berr;
  logic [2:0] blong;
  logic [2:0] bers;
  logic is_rd;
  logic is_wr;
  logic fill_free;
  logic sect_end;
  logic end_q;
  logic eng_stop;
  logic chk_en;
  logic chk_clr;
  logic [63:0] rem;
  logic done_ok;
  logic corr_apply;
  logic drain_pop;
  logic drain_last;
  logic sec_hit;

  assign req = avs_read_i | avs_write_i;
  // One wait cycle, so read data can be registered
  assign avs_waitrequest_o = req & ~ack;
  assign wr_acc = avs_write_i & ack;
  assign rd_acc = avs_read_i & ack;
  assign wa = {avs_address_i[5:2], 2'b00};

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      ack <= 1'b0;
    else
      ack <= req & ~ack;
  end

  // Link clock is slow and free of our clock, so both lines get the same two stages
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      clk_s <= 3'h0;
      dat_s <= 2'h0;
    end
    else
    begin
      clk_s <= {clk_s[1:0], rd_clk_i};
      dat_s <= {dat_s[0], rd_data_i};
    end
  end
  assign edge_p = clk_s[1] & ~clk_s[2];

  assign is_rd = (op == OP_NRD) | (op == OP_RRD) | (op == OP_ERD);
  assign is_wr = (op == OP_NWR) | (op == OP_RWR) | (op == OP_DIAG);
  assign fill_free = (bst[fill_ix] == B_FREE);
  assign sect_end = (st == ST_XFER) & edge_p & (bitc == `DSEBC_BIT_LAST) & (bcnt == `DSEBC_SECT_LAST);
  // Diagnostic stops only after its syndrome is latched, so the buffer records the right mode
  assign eng_stop = ((st == ST_IDLE) & (is_rd | is_wr) & ~fill_free)
                  | ((st == ST_TAIL) & edge_p & is_wr)
                  | (end_q & (op == OP_DIAG));
  assign rbyte = {sh[6:0], dat_s[1]};
  // Normal write replaces bytes past the data field with the running remainder
  assign src = ((op == OP_NWR) && (bcnt >= `DSEBC_CHK_FIRST)) ? rem[63:56]
             : mem[fill_ix][bcnt]; // [RULE2]
  // Raw commands and erasure reads never reach the checker
  assign chk_en = (st == ST_XFER) & edge_p & (bitc == `DSEBC_BIT_LAST)
                & ((op == OP_NRD) | (op == OP_NWR) | (op == OP_DIAG)); // [RULE3] [RULE6]
  assign chk_clr = (st == ST_IDLE);

  function automatic logic [1:0] nxt(input logic [1:0] i);
    return (i >= nbm1) ? 2'h0 : i + 2'h1;
  endfunction : nxt

  dsebc_syndrome u_syn (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .clr_i(chk_clr),
    .en_i(chk_en),
    .din_i(is_rd ? rbyte : src),
    .rem_o(rem)
  );

  // Configuration; write and diagnostic commands cover one sector, reads run until cleared or no buffer is free
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      op <= OP_IDLE;
      nbm1 <= 2'h0;
      sec_thr <= 8'h00;
      med_thr <= 8'h00;
    end
    else
    begin
      if (wr_acc && wa == `DSEBC_CTRL)
      begin
        op <= dsebc_op_e'(avs_writedata_i[`DSEBC_CTRL_OP]);
        nbm1 <= (avs_writedata_i[`DSEBC_CTRL_NB] > `DSEBC_NB_MAX) ? `DSEBC_NB_MAX
              : avs_writedata_i[`DSEBC_CTRL_NB];
      end
      else if (eng_stop)
        op <= OP_IDLE; // [RULE12]
      if (wr_acc && wa == `DSEBC_THR)
      begin
        sec_thr <= avs_writedata_i[`DSEBC_THR_SEC];
        med_thr <= avs_writedata_i[`DSEBC_THR_MED];
      end
    end
  end

  // Sector engine; wr_data moves on link clock rising edges and clears with the gates; gates open leaving idle, drop at sector/tail end or op clear
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st <= ST_IDLE;
      bitc <= 3'h0;
      bcnt <= 8'h00;
      sh <= 8'h00;
      link_o <= '0;
    end
    else
    begin
      unique case (st)
        ST_IDLE:
        begin
          bitc <= 3'h0;
          bcnt <= 8'h00;
          // Wait out the latch cycle so fill_free reflects the buffer just closed
          if ((is_rd | is_wr) && fill_free && !end_q)
          begin
            st <= ST_XFER;
            // Diagnostic borrows the read gate only for link clocks; nothing reaches the medium
            link_o.rd_gate <= is_rd | (op == OP_DIAG);
            link_o.wr_gate <= (op == OP_NWR) | (op == OP_RWR); // [RULE5]
          end
        end
        ST_XFER:
        begin
          if (op == OP_IDLE)
          begin
            st <= ST_IDLE;
            link_o <= '0;
          end
          else if (edge_p)
          begin
            sh <= rbyte;
            bitc <= bitc + 3'h1;
            link_o.wr_data <= link_o.wr_gate & src[~bitc];
            if (bitc == `DSEBC_BIT_LAST)
              bcnt <= bcnt + 8'h01;
            if (sect_end)
            begin
              st <= ((op == OP_NWR) || (op == OP_RWR)) ? ST_TAIL : ST_IDLE;
              link_o.rd_gate <= 1'b0;
            end
          end
        end
        ST_TAIL:
        begin
          // Hold the gate one more link edge so the last bit is taken
          if (edge_p || op == OP_IDLE)
          begin
            st <= ST_IDLE;
            link_o <= '0;
          end
        end
      endcase
    end
  end

  // Sector sample point: remainder already includes the last byte
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      end_q <= 1'b0;
    else
      end_q <= sect_end & (is_rd | (op == OP_DIAG));
  end

  assign done_ok = wr_acc & (wa == `DSEBC_CORR) & avs_writedata_i[`DSEBC_CORR_DONE]
                 & (bst[corr_ix] == B_FULL); // [RULE10]
  assign sec_hit = done_ok & (sec_thr != 8'h00)
                 & (avs_writedata_i[`DSEBC_CORR_CNT] >= sec_thr);
  assign corr_apply = wr_acc & (wa == `DSEBC_CORR) & avs_writedata_i[`DSEBC_CORR_APPLY]
                    & (avs_writedata_i[`DSEBC_CORR_IDX] <= `DSEBC_SECT_LAST);
  assign drain_pop = rd_acc & (wa == `DSEBC_DATA) & (bst[drain_ix] == B_READY); // [RULE11]
  assign drain_last = drain_pop
                    & (dptr == (blong[drain_ix] ? `DSEBC_SECT_LAST : `DSEBC_DATA_LAST));

  // Buffer storage; raw and erasure reads keep check bytes and pointers in place
  always_ff @(posedge clk_i)
  begin
    if (st == ST_XFER && edge_p && is_rd && bitc == `DSEBC_BIT_LAST)
      mem[fill_ix][bcnt] <= rbyte; // [RULE1] [RULE13] [RULE14] [RULE18]
    else if (wr_acc && wa == `DSEBC_DATA && st == ST_IDLE)
      mem[fill_ix][hptr] <= avs_writedata_i[7:0];
    else if (corr_apply)
      mem[corr_ix][avs_writedata_i[`DSEBC_CORR_IDX]] <=
        mem[corr_ix][avs_writedata_i[`DSEBC_CORR_IDX]] ^ avs_writedata_i[`DSEBC_CORR_XOR];
  end

  // Pointer rotation; nbm1 picks one, two or three buffers
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      fill_ix <= 2'h0;
      corr_ix <= 2'h0;
      drain_ix <= 2'h0;
      hptr <= 8'h00;
      dptr <= 8'h00;
    end
    else
    begin
      if (end_q)
        fill_ix <= nxt(fill_ix); // [RULE7] [RULE8] [RULE9]
      if (done_ok)
        corr_ix <= nxt(corr_ix);
      if (drain_last)
      begin
        drain_ix <= nxt(drain_ix);
        dptr <= 8'h00;
      end
      else if (drain_pop)
        dptr <= dptr + 8'h01;
      if (st == ST_TAIL && edge_p)
        hptr <= 8'h00;
      else if (wr_acc && wa == `DSEBC_DATA && st == ST_IDLE)
        hptr <= (hptr == `DSEBC_SECT_LAST) ? 8'h00 : hptr + 8'h01;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_buf
      always_ff @(posedge clk_i or posedge sys_rst_i)
      begin
        if (sys_rst_i)
        begin
          bst[g] <= B_FREE;
          syn[g] <= `DSEBC_REM_INIT;
          berr[g] <= 1'b0;
          blong[g] <= 1'b0;
          bers[g] <= 1'b0;
        end
        else if (end_q && fill_ix == 2'(g))
        begin
          bst[g] <= B_FULL; // [RULE10]
          syn[g] <= rem; // [RULE21]
          berr[g] <= ((op == OP_NRD) | (op == OP_DIAG)) & (rem != `DSEBC_REM_INIT); // [RULE4]
          blong[g] <= (op != OP_NRD);
          bers[g] <= (op == OP_ERD); // [RULE15]
        end
        else if (done_ok && corr_ix == 2'(g))
          bst[g] <= B_READY; // [RULE11]
        else if (drain_last && drain_ix == 2'(g))
          bst[g] <= B_FREE;
      end
    end
  endgenerate

  // Sticky flags: a new event wins over a same-cycle write-one clear
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rsec <= 1'b0;
      rmed <= 1'b0;
      olost <= 1'b0;
      marg <= 8'h00;
      sect <= 16'h0000;
    end
    else
    begin
      if (sec_hit)
      begin
        rsec <= 1'b1; // [RULE19]
        marg <= marg + 8'h01;
      end
      else if (wr_acc && wa == `DSEBC_STAT && avs_writedata_i[`DSEBC_ST_RSEC])
        rsec <= 1'b0;
      // An event, not a level, so software can still clear it
      if (sec_hit && med_thr != 8'h00 && (marg + 8'h01) >= med_thr)
        rmed <= 1'b1; // [RULE19]
      else if (wr_acc && wa == `DSEBC_STAT && avs_writedata_i[`DSEBC_ST_RMED])
        rmed <= 1'b0;
      if (st == ST_IDLE && is_rd && !fill_free)
        olost <= 1'b1; // [RULE12]
      else if (wr_acc && wa == `DSEBC_STAT && avs_writedata_i[`DSEBC_ST_OLOST])
        olost <= 1'b0;
      // No header compare: the address follows from counting sectors
      if (wr_acc && wa == `DSEBC_SECT)
        sect <= avs_writedata_i[15:0];
      else if (end_q && is_rd)
        sect <= sect + 16'h0001; // [RULE20]
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (req && !ack)
    begin
      case (wa)
        `DSEBC_CTRL: avs_readdata_o <= {26'h0, nbm1, 1'b0, op};
        `DSEBC_STAT: avs_readdata_o <= {21'h0, olost, rmed, rsec, 3'h0, bers[corr_ix],
                                        berr[corr_ix], bst[drain_ix] == B_READY,
                                        bst[corr_ix] == B_FULL, st != ST_IDLE}; // [RULE21]
        `DSEBC_DATA: avs_readdata_o <= {24'h0,
                                        (bst[drain_ix] == B_READY) ? mem[drain_ix][dptr] : 8'h00};
        `DSEBC_SYNLO: avs_readdata_o <= syn[corr_ix][31:0];
        `DSEBC_SYNHI: avs_readdata_o <= syn[corr_ix][63:32];
        `DSEBC_THR: avs_readdata_o <= {16'h0, med_thr, sec_thr};
        `DSEBC_SECT: avs_readdata_o <= {16'h0, sect};
        default: avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_req;
    req && avs_waitrequest_o;
  endsequence

  bus_answer_a: assert property (s_req |=> !avs_waitrequest_o)
    else $error("bus request not answered after one wait cycle");
  raw_bypass_a: assert property ((op == OP_RRD || op == OP_RWR || op == OP_ERD) |-> !chk_en) // [RULE3]
    else $error("checker active during raw transfer");
  diag_inhibit_a: assert property ((op == OP_DIAG) |-> !link_o.wr_gate) // [RULE5]
    else $error("write gate raised in diagnostic mode");
  diag_check_a: assert property ((op == OP_DIAG && st == ST_XFER && edge_p
                                  && bitc == `DSEBC_BIT_LAST) |-> chk_en) // [RULE6]
    else $error("diagnostic byte not fed to checker");
  err_flag_a: assert property ((end_q && op == OP_NRD && rem != `DSEBC_REM_INIT)
                               |=> berr[$past(fill_ix)]) // [RULE4]
    else $error("nonzero syndrome not flagged");
  full_after_end_a: assert property (end_q |=> bst[$past(fill_ix)] == B_FULL
                                     && syn[$past(fill_ix)] == $past(rem)) // [RULE10]
    else $error("buffer not full with its syndrome");
  release_a: assert property ((rd_acc && wa == `DSEBC_DATA && bst[drain_ix] != B_READY)
                              |=> $stable(dptr) && $stable(drain_ix)) // [RULE11]
    else $error("uncorrected buffer drained");
  orient_a: assert property ((st == ST_IDLE && is_rd && !fill_free)
                             |=> olost && op == OP_IDLE ##1 st == ST_IDLE) // [RULE12]
    else $error("overrun not reported");
  retire_a: assert property ((done_ok && sec_thr != 8'h00
                              && avs_writedata_i[`DSEBC_CORR_CNT] >= sec_thr) |=> rsec) // [RULE19]
    else $error("sector retire flag missing");
  medium_retire_a: assert property ((sec_hit && med_thr != 8'h00
                                     && (marg + 8'h01) >= med_thr) |=> rmed) // [RULE19]
    else $error("medium retire flag missing");
  diag_gate_a: assert property ((st == ST_XFER && op == OP_DIAG) |-> link_o.rd_gate) // [RULE6]
    else $error("diagnostic transfer without link gate");
endmodule : dsebc_ctrl
`default_nettype wire

/* hdl/dsebc_syndrome.sv */
// Byte-wide check generator and syndrome calculator
`timescale 1ns/1ps
`default_nettype none
`include "dsebc_regs.svh"
module dsebc_syndrome
  import dsebc_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clr_i,
  input wire logic en_i,
  input wire logic [7:0] din_i,
  output logic [63:0] rem_o
);
  function automatic logic [63:0] step(input logic [63:0] r, input logic [7:0] d);
    logic [63:0] x;
    logic fb;
    x = r;
    for (int i = 7; i >= 0; i--)
    begin
      fb = x[63] ^ d[i];
      x = {x[62:0], 1'b0} ^ ({64{fb}} & `DSEBC_POLY);
    end
    return x;
  endfunction : step

  // Feeding the top remainder byte back shifts it out, so generate and check share one path
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      rem_o <= `DSEBC_REM_INIT;
    else if (clr_i)
      rem_o <= `DSEBC_REM_INIT;
    else if (en_i)
      rem_o <= step(rem_o, din_i);
  end
endmodule : dsebc_syndrome
`default_nettype wire

/* shared/dsebc_pkg.sv */
// Types shared by the sector ECC buffer controller
package dsebc_pkg;
  typedef enum logic [2:0] {
    OP_IDLE = 3'h0, OP_NRD = 3'h1, OP_NWR = 3'h2, OP_RRD = 3'h3,
    OP_RWR = 3'h4, OP_DIAG = 3'h5, OP_ERD = 3'h6
  } dsebc_op_e;
  typedef enum logic [2:0] {B_FREE = 3'h1, B_FULL = 3'h2, B_READY = 3'h4} dsebc_bst_e;
  typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_XFER = 3'h2, ST_TAIL = 3'h4} dsebc_st_e;
  typedef struct packed {
    logic rd_gate;
    logic wr_gate;
    logic wr_data;
  } dsebc_link_s;
endpackage : dsebc_pkg

/* shared/dsebc_regs.svh */
// Register offsets, field ranges and sector constants of the sector ECC buffer controller
`ifndef DSEBC_REGS_SVH
`define DSEBC_REGS_SVH
`define DSEBC_CTRL 6'h00
`define DSEBC_STAT 6'h04
`define DSEBC_DATA 6'h08
`define DSEBC_SYNLO 6'h0C
`define DSEBC_SYNHI 6'h10
`define DSEBC_CORR 6'h14
`define DSEBC_THR 6'h18
`define DSEBC_SECT 6'h1C
`define DSEBC_CTRL_OP 2:0
`define DSEBC_CTRL_NB 5:4
`define DSEBC_ST_RSEC 8
`define DSEBC_ST_RMED 9
`define DSEBC_ST_OLOST 10
`define DSEBC_CORR_XOR 7:0
`define DSEBC_CORR_IDX 15:8
`define DSEBC_CORR_CNT 23:16
`define DSEBC_CORR_APPLY 30
`define DSEBC_CORR_DONE 31
`define DSEBC_THR_SEC 7:0
`define DSEBC_THR_MED 15:8
`define DSEBC_DATA_LAST 8'd127
`define DSEBC_CHK_FIRST 8'd128
`define DSEBC_SECT_LAST 8'd135
`define DSEBC_BIT_LAST 3'h7
`define DSEBC_NB_MAX 2'h2
`define DSEBC_POLY 64'h42F0E1EBA9EA3693
`define DSEBC_REM_INIT 64'h0
`endif

/* test/dsebc_ctrl_bench.sv */
// Self-checking bench for the sector ECC buffer controller
`timescale 1ns/1ps
`default_nettype none
`include "dsebc_regs.svh"
module dsebc_ctrl_bench
  import dsebc_pkg::*;
;
  logic clk_i, sys_rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic rd_clk_i, rd_data_i, ers, diag, wg_seen;
  logic [5:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [63:0] syn;
  logic [7:0] sb [0:135];
  dsebc_link_s link_o;
  int error_cnt, total_checks, seed, i, m;

  dsebc_ctrl dsebc_ctrl_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .rd_clk_i(rd_clk_i), .rd_data_i(rd_data_i),
    .link_o(link_o));
  dsebc_drive dsebc_drive_inst (.link_i(link_o), .ers_i(ers), .rd_clk_o(rd_clk_i),
    .rd_data_o(rd_data_i));

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
    if (sys_rst_i)
      wg_seen <= 1'b0;
    else if (diag && link_o.wr_gate === 1'b1)
      wg_seen <= 1'b1;

  task automatic finish_test();
    if (error_cnt == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  // One Avalon access; the answer edge is the only sampling point
  task automatic av(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= ~w;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 20);
    if (n >= 20)
    begin
      error_cnt++;
      finish_test();
    end
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : av

  task automatic wait_stat(input int b, input logic v);
    int n;
    n = 0;
    do
    begin
      av(1'b0, `DSEBC_STAT, 32'h0);
      n++;
    end
    while (q[b] !== v && n < 12000);
    if (n >= 12000)
    begin
      error_cnt++;
      finish_test();
    end
  endtask : wait_stat

  task automatic do_reset();
    sys_rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
  endtask : do_reset

  // 136 bytes always, so the host pointer wraps back to zero
  task automatic run_wr(input logic [31:0] op, input int b, input logic v);
    for (int k = 0; k < 136; k++)
      av(1'b1, `DSEBC_DATA, {24'h0, sb[k]});
    av(1'b1, `DSEBC_CTRL, op);
    wait_stat(b, v);
  endtask : run_wr

  // Read stops with orientation lost once every enabled buffer holds a sector
  task automatic read_run(input logic [31:0] op);
    av(1'b1, `DSEBC_CTRL, op);
    wait_stat(10, 1'b1);
  endtask : read_run

  task automatic drain(input int n);
    for (int k = 0; k < n; k++)
    begin
      av(1'b0, `DSEBC_DATA, 32'h0);
      chk("pop byte", q, {24'h0, sb[k]});
    end
  endtask : drain

  function automatic logic [63:0] crc(input int n);
    logic [63:0] r;
    r = `DSEBC_REM_INIT;
    for (int k = 0; k < n * 8; k++)
      r = {r[62:0], 1'b0} ^ ((r[63] ^ sb[k / 8][7 - k % 8]) ? `DSEBC_POLY : 64'h0);
    return r;
  endfunction : crc

  task automatic syn_chk();
    av(1'b0, `DSEBC_SYNLO, 32'h0);
    chk("syndrome low", q, syn[31:0]);
    av(1'b0, `DSEBC_SYNHI, 32'h0);
    chk("syndrome high", q, syn[63:32]);
  endtask : syn_chk

  initial
  begin
    seed = 32'h0DBF2E4A;
    error_cnt = 0;
    total_checks = 0;
    sys_rst_i = 1'b1;
    {avs_read_i, avs_write_i, ers, diag} = 4'h0;
    avs_address_i = 6'h00;
    avs_writedata_i = 32'h0;
    do_reset();
    av(1'b0, `DSEBC_STAT, 32'h0);
    chk("status after reset", q, 32'h0);
    av(1'b1, 6'h3C, 32'hFFFFFFFF);
    av(1'b0, 6'h3C, 32'h0);
    chk("unmapped", q, 32'h0);
    for (i = 0; i < 136; i++)
      sb[i] = $random(seed);
    run_wr(32'h2, 0, 1'b0);
    syn = crc(128);
    for (i = 0; i < 136; i++)
      chk("written byte", dsebc_drive_inst.wbuf[i], (i < 128) ? sb[i] : syn[8 * (135 - i) +: 8]);
    // Good record, then a simulated error pattern before the raw write
    for (i = 0; i < 8; i++)
      sb[128 + i] = syn[8 * (7 - i) +: 8];
    sb[3] = sb[3] ^ 8'h5A;
    do_reset();
    run_wr(32'h4, 0, 1'b0);
    for (i = 0; i < 136; i++)
      chk("raw written byte", dsebc_drive_inst.wbuf[i], sb[i]);
    do_reset();
    for (i = 0; i < 136; i++)
      dsebc_drive_inst.rec[i] = sb[i];
    av(1'b1, `DSEBC_THR, 32'h00000101);
    read_run(32'h1);
    chk("full with error", q[3:0], 4'hA);
    av(1'b0, `DSEBC_DATA, 32'h0);
    chk("pop before release", q, 32'h0);
    syn = crc(136);
    syn_chk();
    av(1'b1, `DSEBC_CORR, 32'h40000577);
    av(1'b1, `DSEBC_CORR, 32'h80010000);
    av(1'b0, `DSEBC_STAT, 32'h0);
    chk("ready and retire", {q[9:8], q[2:1]}, 4'hE);
    sb[5] = sb[5] ^ 8'h77;
    drain(128);
    av(1'b1, `DSEBC_STAT, 32'h00000700);
    av(1'b0, `DSEBC_STAT, 32'h0);
    chk("sticky clear", q[10:8], 3'h0);
    av(1'b0, `DSEBC_SECT, 32'h0);
    chk("sector count", q[15:0], 16'h0001);
    for (m = 0; m < 2; m++)
    begin
      do_reset();
      ers = m[0];
      for (i = 0; i < 136; i++)
        dsebc_drive_inst.ptr[i] = $random(seed);
      read_run(m ? 32'h6 : 32'h3);
      chk("erasure and error", q[4:3], {m[0], 1'b0});
      syn = 64'h0;
      syn_chk();
      av(1'b1, `DSEBC_CORR, 32'h80000000);
      for (i = 0; i < 136; i++)
        sb[i] = m ? dsebc_drive_inst.ptr[i] : dsebc_drive_inst.rec[i];
      drain(136);
    end
    ers = 1'b0;
    do_reset();
    for (i = 0; i < 136; i++)
      sb[i] = $random(seed);
    diag = 1'b1;
    run_wr(32'h5, 1, 1'b1);
    diag = 1'b0;
    chk("write gate", wg_seen, 1'b0);
    syn = crc(136);
    syn_chk();
    av(1'b1, `DSEBC_CORR, 32'h80000000);
    drain(136);
    do_reset();
    read_run(32'h11);
    av(1'b0, `DSEBC_SECT, 32'h0);
    chk("two buffers", q[15:0], 16'h0002);
    finish_test();
  end
endmodule : dsebc_ctrl_bench
`default_nettype wire

/* test/dsebc_drive.sv */
// Behavioural disk drive on the serial link of the sector controller
`timescale 1ns/1ps
`default_nettype none
module dsebc_drive
  import dsebc_pkg::*;
(
  input wire dsebc_link_s link_i,
  input wire logic ers_i,
  output logic rd_clk_o,
  output logic rd_data_o
);
  logic [7:0] rec [0:135];
  logic [7:0] ptr [0:135];
  logic [7:0] wbuf [0:135];
  logic rd;
  int e;
  int last;

  // Pointer bytes stand in the byte slot that they mark
  function automatic logic pick(input int k);
    logic [7:0] b;
    b = ers_i ? ptr[k / 8] : rec[k / 8];
    return b[7 - k % 8];
  endfunction : pick

  initial
  begin
    rd_clk_o = 1'b0;
    rd_data_o = 1'b1;
    forever
    begin
      wait (link_i.rd_gate || link_i.wr_gate);
      rd = link_i.rd_gate;
      last = rd ? 1088 : 1089;
      // Small skew keeps link edges off the system clock grid
      #3;
      rd_data_o = pick(0);
      for (e = 1; e <= last && (link_i.rd_gate || link_i.wr_gate); e++)
      begin
        #160 rd_clk_o = 1'b1;
        // Controller launches a bit after an edge, so the first edge carries nothing
        if (!rd && e >= 2)
          wbuf[(e - 2) / 8][7 - (e - 2) % 8] = link_i.wr_data;
        if (e == last)
          break;
        #160 rd_clk_o = 1'b0;
        if (rd)
          rd_data_o = pick(e);
      end
      wait (!(link_i.rd_gate || link_i.wr_gate));
      // Clock stands still between frames; released line shows no stale bit
      rd_clk_o = 1'b0;
      rd_data_o = ~rd_data_o;
    end
  end
endmodule : dsebc_drive
`default_nettype wire
